/* File: rtl/headset_monitor_router.sv */
// Headphone routing, sidetone mixing and button control of the announcer console
`timescale 1ns/10ps
`default_nettype none

`include "hmr_defines.svh"

module headset_monitor_router #(
    parameter int SAMPLE_W = `HMR_SAMPLE_W,
    parameter int KNOB_W   = `HMR_KNOB_W
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic signed [SAMPLE_W-1:0]    i_rx_ch1,
    input  wire logic signed [SAMPLE_W-1:0]    i_rx_ch2,
    input  wire logic signed [SAMPLE_W-1:0]    i_rx_ch3,
    input  wire logic signed [SAMPLE_W-1:0]    i_rx_ch4,
    input  wire logic                          i_rx_valid,
    input  wire logic signed [SAMPLE_W-1:0]    i_mic_sample,
    input  wire logic                          i_mic_valid,
    input  wire logic        [KNOB_W-1:0]      i_knob_a,
    input  wire logic        [KNOB_W-1:0]      i_knob_b,
    input  wire logic        [KNOB_W-1:0]      i_knob_c,
    input  wire hmr_pkg::hp_mode_t             i_hp_mode,
    input  wire hmr_pkg::sidetone_t            i_sidetone_mode,
    input  wire hmr_pkg::main_mode_t           i_main_mode,
    input  wire hmr_pkg::tb_mode_t             i_tb_mode,
    input  wire hmr_pkg::rc_assign_t           i_rc1_assign,
    input  wire hmr_pkg::rc_assign_t           i_rc2_assign,
    input  wire logic                          i_rc1_is_tally,
    input  wire logic                          i_led_scheme,
    input  wire logic        [1:0]             i_preamp_gain,
    input  wire logic                          i_phantom_en,
    input  wire logic                          i_main_btn_n,
    input  wire logic                          i_tb_btn_n,
    input  wire logic                          i_rc1_n,
    input  wire logic                          i_rc2_n,
    output logic signed      [SAMPLE_W-1:0]    o_hp_left,
    output logic signed      [SAMPLE_W-1:0]    o_hp_right,
    output logic                               o_hp_valid,
    output logic signed      [SAMPLE_W-1:0]    o_main_tx,
    output logic signed      [SAMPLE_W-1:0]    o_tb_tx,
    output logic                               o_tx_valid,
    output logic                               o_main_on,
    output logic                               o_tb_on,
    output logic                               o_mic_out_mute,
    output logic                               o_tally_out,
    output logic                               o_tally_oe_n,
    output logic             [1:0]             o_preamp_gain,
    output logic                               o_phantom_on,
    output logic                               o_main_led_red,
    output logic                               o_main_led_green,
    output logic                               o_tb_led_red,
    output logic                               o_tb_led_green
);

    // Three mix terms per side, left terms first
    localparam int TERMS = 6;

    hmr_pkg::state_t          st_reg;      // Registered state
    hmr_pkg::state_t          st_next;     // Next state

    logic signed [SAMPLE_W-1:0] term_src  [TERMS];  // Sample feeding each term
    logic        [KNOB_W-1:0]   term_gain [TERMS];  // Knob value for each term
    logic signed [SAMPLE_W-1:0] term_out  [TERMS];  // Scaled term
    logic signed [SAMPLE_W-1:0] sidetone;           // Mic audio when sidetone is live
    logic        [KNOB_W-1:0]   bal_l;              // Balance gain, left side
    logic        [KNOB_W-1:0]   bal_r;              // Balance gain, right side
    logic        [KNOB_W-1:0]   gain_al;            // Knob A times left balance
    logic        [KNOB_W-1:0]   gain_ar;            // Knob A times right balance
    logic        [KNOB_W:0]     bal_tmp_l;          // Doubled balance before clipping
    logic        [KNOB_W:0]     bal_tmp_r;          // Doubled balance before clipping
    logic        [2*KNOB_W-1:0] prod_l;             // Level times balance, left
    logic        [2*KNOB_W-1:0] prod_r;             // Level times balance, right
    logic                       rc1_hit;            // Remote 1 active and not tally
    logic                       rc2_hit;            // Remote 2 active
    logic                       main_press;         // Main button or its remotes
    logic                       tb_press;           // Talkback button or its remotes
    logic signed [SAMPLE_W-1:0] sum_l;              // Saturated left mix
    logic signed [SAMPLE_W-1:0] sum_r;              // Saturated right mix

    // Clip a wide mix back into the sample range
    function automatic logic signed [SAMPLE_W-1:0] saturate(input logic signed [`HMR_SUM_W-1:0] value);
        logic signed [`HMR_SUM_W-1:0] max_v;
        logic signed [`HMR_SUM_W-1:0] min_v;
        max_v = `HMR_SUM_W'((2 ** (SAMPLE_W - 1)) - 1);
        min_v = -max_v - `HMR_SUM_W'(1);
        if (value > max_v)
        begin
            saturate = max_v[SAMPLE_W-1:0];
        end
        else if (value < min_v)
        begin
            saturate = min_v[SAMPLE_W-1:0];
        end
        else
        begin
            saturate = value[SAMPLE_W-1:0];
        end
    endfunction

    // Balance: centre gives both sides nearly full, turning away fades one side
    always_comb
    begin
        bal_tmp_l = {1'b0, `HMR_KNOB_FULL - i_knob_b} << 1;
        bal_tmp_r = {1'b0, i_knob_b} << 1;
        bal_l     = bal_tmp_l[KNOB_W] ? `HMR_KNOB_FULL : bal_tmp_l[KNOB_W-1:0];
        bal_r     = bal_tmp_r[KNOB_W] ? `HMR_KNOB_FULL : bal_tmp_r[KNOB_W-1:0];
        prod_l    = i_knob_a * bal_l;
        prod_r    = i_knob_a * bal_r;
        gain_al   = prod_l[2*KNOB_W-1:KNOB_W];
        gain_ar   = prod_r[2*KNOB_W-1:KNOB_W];
    end

    // Sidetone follows the chosen condition; off suits a full-mix cue feed
    always_comb
    begin
        unique case (i_sidetone_mode)
            hmr_pkg::st_off:           sidetone = '0;
            hmr_pkg::st_always:        sidetone = st_reg.mic_hold;
            hmr_pkg::st_with_main:     sidetone = st_reg.main_on ? st_reg.mic_hold : '0;
            hmr_pkg::st_with_talkback: sidetone = st_reg.tb_on ? st_reg.mic_hold : '0;
        endcase
    end

    // Source and knob for each mix term, chosen by headphone mode
    always_comb
    begin
        for (int k = 0; k < TERMS; k++)
        begin
            term_src[k]  = '0;
            term_gain[k] = '0;
        end
        unique case (i_hp_mode)
            hmr_pkg::dual_mono_with_sidetone_mode:
            begin
                term_src[0] = i_rx_ch1;  term_gain[0] = i_knob_a;
                term_src[3] = i_rx_ch2;  term_gain[3] = i_knob_b;
                term_src[2] = sidetone;  term_gain[2] = i_knob_c;
                term_src[5] = sidetone;  term_gain[5] = i_knob_c;
            end
            hmr_pkg::stereo_balance_sidetone_mode:
            begin
                term_src[0] = i_rx_ch1;  term_gain[0] = gain_al;
                term_src[3] = i_rx_ch2;  term_gain[3] = gain_ar;
                term_src[2] = sidetone;  term_gain[2] = i_knob_c;
                term_src[5] = sidetone;  term_gain[5] = i_knob_c;
            end
            hmr_pkg::two_pair_sidetone_mode:
            begin
                term_src[0] = i_rx_ch1;  term_gain[0] = i_knob_a;
                term_src[3] = i_rx_ch2;  term_gain[3] = i_knob_a;
                term_src[1] = i_rx_ch3;  term_gain[1] = i_knob_b;
                term_src[4] = i_rx_ch4;  term_gain[4] = i_knob_b;
                term_src[2] = sidetone;  term_gain[2] = i_knob_c;
                term_src[5] = sidetone;  term_gain[5] = i_knob_c;
            end
            hmr_pkg::dual_mono_plus_pair_mode:
            begin
                term_src[0] = i_rx_ch1;  term_gain[0] = i_knob_a;
                term_src[3] = i_rx_ch2;  term_gain[3] = i_knob_b;
                term_src[1] = i_rx_ch3;  term_gain[1] = i_knob_c;
                term_src[4] = i_rx_ch4;  term_gain[4] = i_knob_c;
            end
            hmr_pkg::dual_mono_both_sides_mode:
            begin
                term_src[0] = i_rx_ch1;  term_gain[0] = i_knob_a;
                term_src[3] = i_rx_ch1;  term_gain[3] = i_knob_a;
                term_src[1] = i_rx_ch2;  term_gain[1] = i_knob_b;
                term_src[4] = i_rx_ch2;  term_gain[4] = i_knob_b;
                term_src[2] = i_rx_ch3;  term_gain[2] = i_knob_c;
                term_src[5] = i_rx_ch4;  term_gain[5] = i_knob_c;
            end
            default:
            begin
                // Unused codes leave the headphones silent
                term_src[0] = '0;
            end
        endcase
    end

    // One multiplier per term; knobs only set gain, audio stays digital
    for (genvar g = 0; g < TERMS; g++)
    begin : g_term
        hmr_scaler #(
            .SAMPLE_W (SAMPLE_W),
            .KNOB_W   (KNOB_W)
        ) u_scaler (
            .i_sample (term_src[g]),
            .i_gain   (term_gain[g]),
            .o_scaled (term_out[g])
        );
    end

    // Sum three terms per side in wide arithmetic, then clip
    always_comb
    begin
        sum_l = saturate(`HMR_SUM_W'(term_out[0]) + `HMR_SUM_W'(term_out[1])
                         + `HMR_SUM_W'(term_out[2]));
        sum_r = saturate(`HMR_SUM_W'(term_out[3]) + `HMR_SUM_W'(term_out[4])
                         + `HMR_SUM_W'(term_out[5]));
    end

    // Press decode after synchronisers; remote pins are active low
    always_comb
    begin
        rc1_hit    = !st_reg.rc1_sync[1] && !i_rc1_is_tally;
        rc2_hit    = !st_reg.rc2_sync[1];
        main_press = !st_reg.main_sync[1]
                     || (rc1_hit && i_rc1_assign == hmr_pkg::rc_main)
                     || (rc2_hit && i_rc2_assign == hmr_pkg::rc_main);
        tb_press   = !st_reg.tb_sync[1]
                     || (rc1_hit && i_rc1_assign == hmr_pkg::rc_talkback)
                     || (rc2_hit && i_rc2_assign == hmr_pkg::rc_talkback);
    end

    // Next state
    always_comb
    begin
        st_next = st_reg;

        // Two-flop synchronisers for the pins
        st_next.main_sync = {st_reg.main_sync[0], i_main_btn_n};
        st_next.tb_sync   = {st_reg.tb_sync[0], i_tb_btn_n};
        st_next.rc1_sync  = {st_reg.rc1_sync[0], i_rc1_n};
        st_next.rc2_sync  = {st_reg.rc2_sync[0], i_rc2_n};
        st_next.main_prev = main_press;
        st_next.tb_prev   = tb_press;

        // Latches toggle on each new press, cleared outside latching mode
        if (i_main_mode != hmr_pkg::main_latching)
        begin
            st_next.main_latch = `HMR_LATCH_RST;
        end
        else if (main_press && !st_reg.main_prev)
        begin
            st_next.main_latch = !st_reg.main_latch;
        end
        if (i_tb_mode != hmr_pkg::tb_latching)
        begin
            st_next.tb_latch = `HMR_LATCH_RST;
        end
        else if (tb_press && !st_reg.tb_prev)
        begin
            st_next.tb_latch = !st_reg.tb_latch;
        end

        // Main output state per button mode
        unique case (i_main_mode)
            hmr_pkg::main_push_to_talk: st_next.main_on = main_press;
            hmr_pkg::main_push_to_mute: st_next.main_on = !main_press;
            hmr_pkg::main_latching:     st_next.main_on = st_next.main_latch;
            hmr_pkg::main_always_on:    st_next.main_on = 1'b1;
            default:                    st_next.main_on = 1'b0;
        endcase

        // Talkback state per button mode
        unique case (i_tb_mode)
            hmr_pkg::tb_push_to_talk: st_next.tb_on = tb_press;
            hmr_pkg::tb_latching:     st_next.tb_on = st_next.tb_latch;
            default:                  st_next.tb_on = 1'b0;
        endcase

        // Tally follows main state only when the shared pin is an output
        st_next.tally = i_rc1_is_tally && st_reg.main_on;

        // Mic sample captured and sent to both transmit channels, gated
        st_next.tx_valid = i_mic_valid;
        if (i_mic_valid)
        begin
            st_next.mic_hold = i_mic_sample;
            st_next.main_tx  = st_reg.main_on ? i_mic_sample : '0;
            st_next.tb_tx    = st_reg.tb_on ? i_mic_sample : '0;
        end

        // Headphone frame; any frame rate works, each valid is one frame
        st_next.hp_valid = i_rx_valid;
        if (i_rx_valid)
        begin
            st_next.hp_l = sum_l;
            st_next.hp_r = sum_r;
        end

        // Analog-side controls
        st_next.gain    = i_preamp_gain;
        st_next.phantom = i_phantom_en;
    end

    // State register; pins idle high so synchronisers reset high
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg            <= '0;
            st_reg.main_sync  <= `HMR_PIN_IDLE;
            st_reg.tb_sync    <= `HMR_PIN_IDLE;
            st_reg.rc1_sync   <= `HMR_PIN_IDLE;
            st_reg.rc2_sync   <= `HMR_PIN_IDLE;
            st_reg.main_latch <= `HMR_LATCH_RST;
            st_reg.tb_latch   <= `HMR_LATCH_RST;
            st_reg.hp_l       <= `HMR_SAMPLE_RST;
            st_reg.hp_r       <= `HMR_SAMPLE_RST;
            st_reg.gain       <= `HMR_GAIN_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state; tally pin enable from i_rc1_is_tally
    assign o_hp_left      = st_reg.hp_l;
    assign o_hp_right     = st_reg.hp_r;
    assign o_hp_valid     = st_reg.hp_valid;
    assign o_main_tx      = st_reg.main_tx;
    assign o_tb_tx        = st_reg.tb_tx;
    assign o_tx_valid     = st_reg.tx_valid;
    assign o_main_on      = st_reg.main_on;
    assign o_tb_on        = st_reg.tb_on;
    assign o_mic_out_mute = !st_reg.main_on;
    assign o_tally_out    = st_reg.tally;
    // Pin released whenever it serves as remote input 1
    assign o_tally_oe_n   = !i_rc1_is_tally;
    assign o_preamp_gain  = st_reg.gain;
    assign o_phantom_on   = st_reg.phantom;

    // Scheme 0 lights green when live, red when off; scheme 1 swaps them
    assign o_main_led_green = st_reg.main_on ^ i_led_scheme;
    assign o_main_led_red   = !(st_reg.main_on ^ i_led_scheme);
    assign o_tb_led_green   = st_reg.tb_on ^ i_led_scheme;
    assign o_tb_led_red     = !(st_reg.tb_on ^ i_led_scheme);

endmodule

`default_nettype wire

/* File: rtl/hmr_defines.svh */
// Constants for the headset monitor router: widths, reset values, knob scale
`ifndef HMR_DEFINES_SVH
`define HMR_DEFINES_SVH

// Audio sample width, up to 24-bit words from the network and the mic converter
`define HMR_SAMPLE_W 24
// Knob position width, unsigned, full scale is unity gain minus one step
`define HMR_KNOB_W 8
// Mix accumulator width, room for three full-scale terms
`define HMR_SUM_W 26
// Knob full-scale value
`define HMR_KNOB_FULL 8'hFF
// Idle level of the active-low button and remote pins
`define HMR_PIN_IDLE 2'h3
// Latched button states start off
`define HMR_LATCH_RST 1'h0
// Audio outputs start silent
`define HMR_SAMPLE_RST 24'h00_0000
// Preamp gain selection after reset, lowest gain
`define HMR_GAIN_RST 2'h0

`endif

/* File: rtl/hmr_pkg.sv */
// Types shared by the headset monitor router files
`include "hmr_defines.svh"

package hmr_pkg;

    // Headphone source assignments, one of five
    typedef enum logic [2:0] {
        dual_mono_with_sidetone_mode,
        stereo_balance_sidetone_mode,
        two_pair_sidetone_mode,
        dual_mono_plus_pair_mode,
        dual_mono_both_sides_mode
    } hp_mode_t;

    // Main button behaviours
    typedef enum logic [2:0] {
        main_push_to_talk,
        main_push_to_mute,
        main_latching,
        main_always_on,
        main_always_off
    } main_mode_t;

    // Talkback button behaviours
    typedef enum logic [1:0] {
        tb_push_to_talk,
        tb_latching,
        tb_disabled
    } tb_mode_t;

    // What a remote-control input mirrors
    typedef enum logic [1:0] {
        rc_unused,
        rc_main,
        rc_talkback
    } rc_assign_t;

    // When the microphone is fed back into the headphones
    typedef enum logic [1:0] {
        st_off,
        st_always,
        st_with_main,
        st_with_talkback
    } sidetone_t;

    // Whole registered state of the router
    typedef struct packed {
        logic [1:0]                      main_sync;
        logic [1:0]                      tb_sync;
        logic [1:0]                      rc1_sync;
        logic [1:0]                      rc2_sync;
        logic                            main_prev;
        logic                            tb_prev;
        logic                            main_latch;
        logic                            tb_latch;
        logic                            main_on;
        logic                            tb_on;
        logic                            tally;
        logic signed [`HMR_SAMPLE_W-1:0] mic_hold;
        logic signed [`HMR_SAMPLE_W-1:0] hp_l;
        logic signed [`HMR_SAMPLE_W-1:0] hp_r;
        logic                            hp_valid;
        logic signed [`HMR_SAMPLE_W-1:0] main_tx;
        logic signed [`HMR_SAMPLE_W-1:0] tb_tx;
        logic                            tx_valid;
        logic [1:0]                      gain;
        logic                            phantom;
    } state_t;

endpackage

/* File: rtl/hmr_scaler.sv */
// Knob-controlled scaling of one signed audio sample
`timescale 1ns/10ps
`default_nettype none

module hmr_scaler #(
    parameter int SAMPLE_W = 24,
    parameter int KNOB_W   = 8
) (
    input  wire logic signed [SAMPLE_W-1:0] i_sample,
    input  wire logic        [KNOB_W-1:0]   i_gain,
    output logic signed      [SAMPLE_W-1:0] o_scaled
);

    // Full product, knob treated as positive fraction below one
    logic signed [SAMPLE_W+KNOB_W:0] product;

    // Gain never reaches one, so the shifted product always fits the sample width
    always_comb
    begin
        product  = i_sample * $signed({1'b0, i_gain});
        o_scaled = product[KNOB_W +: SAMPLE_W];
    end

endmodule

`default_nettype wire

/* File: testbench/hmr_chk.sv */
// Port checker for the headset monitor router
`timescale 1ns/10ps
`default_nettype none
module hmr_chk (
    input wire logic                   i_clk,
    input wire logic                   i_rst,
    input wire logic                   i_rx_valid,
    input wire logic                   i_mic_valid,
    input wire logic signed [23:0]     i_mic_sample,
    input wire hmr_pkg::main_mode_t    i_main_mode,
    input wire logic                   i_main_btn_n,
    input wire logic                   i_rc1_is_tally,
    input wire logic        [1:0]      i_preamp_gain,
    input wire logic                   i_phantom_en,
    input wire logic                   o_hp_valid,
    input wire logic                   o_tx_valid,
    input wire logic signed [23:0]     o_main_tx,
    input wire logic signed [23:0]     o_tb_tx,
    input wire logic                   o_main_on,
    input wire logic                   o_tb_on,
    input wire logic                   o_mic_out_mute,
    input wire logic                   o_tally_out,
    input wire logic                   o_tally_oe_n,
    input wire logic        [1:0]      o_preamp_gain,
    input wire logic                   o_phantom_on
);
    // Single domain, reset masks everything
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_hp_valid_lag: assert property (i_rx_valid |=> o_hp_valid) else $error("hp valid late");
    a_hp_valid_one: assert property (!i_rx_valid |=> !o_hp_valid) else $error("hp valid stray");
    a_tx_valid_lag: assert property (i_mic_valid |=> o_tx_valid) else $error("tx valid late");
    a_main_tx_pass: assert property (i_mic_valid && o_main_on |=> o_main_tx == $past(i_mic_sample))
        else $error("main tx lost sample");
    a_main_tx_mute: assert property (i_mic_valid && !o_main_on |=> o_main_tx == 0) else $error("main tx live");
    a_tb_tx_mute: assert property (i_mic_valid && !o_tb_on |=> o_tb_tx == 0) else $error("tb tx live");
    a_mic_mute_follow: assert property (o_mic_out_mute == !o_main_on) else $error("mic out mute wrong");
    a_tally_pin_dir: assert property (o_tally_oe_n == !i_rc1_is_tally) else $error("tally drive wrong");
    // Tally lags the main state by one edge
    a_tally_follow: assert property (i_rc1_is_tally && $past(i_rc1_is_tally) && !$past(i_rst)
        |-> o_tally_out == $past(o_main_on)) else $error("tally not following");
    a_press_mute: assert property (i_main_mode == hmr_pkg::main_push_to_mute && $fell(i_main_btn_n)
        |-> ##3 !o_main_on) else $error("press did not mute");
    a_cfg_copy: assert property (!$past(i_rst) |-> o_preamp_gain == $past(i_preamp_gain)
        && o_phantom_on == $past(i_phantom_en)) else $error("config copy wrong");
    c_frame: cover property (i_rx_valid);
    c_mic_live: cover property (i_mic_valid && o_main_on);
    c_tally_on: cover property (i_rc1_is_tally && o_tally_out);
endmodule
bind headset_monitor_router hmr_chk u_chk (.*);
`default_nettype wire

/* File: testbench/hmr_ctrl_model.sv */
// Button, remote and tally pin model with pull-ups
`timescale 1ns/10ps
`default_nettype none
module hmr_ctrl_model (
    input  wire logic [3:0] i_press,
    input  wire logic       i_tally_out,
    input  wire logic       i_tally_oe_n,
    output logic            o_main_btn_n,
    output logic            o_tb_btn_n,
    output logic            o_rc1_n,
    output logic            o_rc2_n
);
    // Contacts pull low, open pins rest high
    assign o_main_btn_n = !i_press[0];
    assign o_tb_btn_n   = !i_press[1];
    // Shared pin shows the driven tally level
    assign o_rc1_n      = i_tally_oe_n ? !i_press[2] : i_tally_out;
    assign o_rc2_n      = !i_press[3];
endmodule
`default_nettype wire

/* File: testbench/headset_monitor_router_tb.sv */
// Self-checking bench for the headset monitor router
`timescale 1ns/10ps
`default_nettype none
module headset_monitor_router_tb;
    logic i_clk = 0, i_rst = 1, i_rx_valid = 0, i_mic_valid = 0, i_rc1_is_tally = 0, i_led_scheme = 0, i_phantom_en = 0;
    logic signed [23:0] i_rx_ch1 = 0, i_rx_ch2 = 0, i_rx_ch3 = 0, i_rx_ch4 = 0, i_mic_sample = 0;
    logic [7:0] i_knob_a = 0, i_knob_b = 0, i_knob_c = 0;
    logic [1:0] i_preamp_gain = 0, o_preamp_gain;
    logic [3:0] press = 0;
    hmr_pkg::hp_mode_t i_hp_mode = hmr_pkg::dual_mono_with_sidetone_mode;
    hmr_pkg::sidetone_t i_sidetone_mode = hmr_pkg::st_always;
    hmr_pkg::main_mode_t i_main_mode = hmr_pkg::main_push_to_mute;
    hmr_pkg::tb_mode_t i_tb_mode = hmr_pkg::tb_push_to_talk;
    hmr_pkg::rc_assign_t i_rc1_assign = hmr_pkg::rc_main, i_rc2_assign = hmr_pkg::rc_talkback;
    logic i_main_btn_n, i_tb_btn_n, i_rc1_n, i_rc2_n, o_hp_valid, o_tx_valid, o_main_on, o_tb_on, o_mic_out_mute;
    logic o_tally_out, o_tally_oe_n, o_phantom_on, o_main_led_red, o_main_led_green, o_tb_led_red, o_tb_led_green;
    logic signed [23:0] o_hp_left, o_hp_right, o_main_tx, o_tb_tx;
    int errors = 0, cmp_count = 0;
    longint st = 0;  // Expected sidetone, last mic sample
    localparam longint FULL = 64'sh0000_0000_007F_FFFF;
    headset_monitor_router u_dut (.*);
    hmr_ctrl_model u_ctl (.i_press(press), .i_tally_out(o_tally_out), .i_tally_oe_n(o_tally_oe_n),
        .o_main_btn_n(i_main_btn_n), .o_tb_btn_n(i_tb_btn_n), .o_rc1_n(i_rc1_n), .o_rc2_n(i_rc2_n));
    always #4 i_clk = ~i_clk;
    function automatic longint g(longint x, longint k);
        return (x * k) >>> 8;
    endfunction
    // Clip to the 24-bit signed range, never wrap
    function automatic logic [23:0] sat(longint v);
        return (v > FULL) ? 24'h7F_FFFF : (v < -FULL) ? 24'h80_0000 : v[23:0];
    endfunction
    task automatic chk_s(string n, logic [23:0] e, logic [23:0] s);
        cmp_count++;
        if (s !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_b(string n, logic e, logic s);
        chk_s(n, {23'h0, e}, {23'h0, s});
    endtask
    task automatic final_report;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One frame, expected mix per mode
    task automatic frame(hmr_pkg::hp_mode_t m, longint c1, c2, c3, c4, logic [7:0] a, b, c);
        longint l, r, bl, br;
        @(negedge i_clk);
        {i_rx_ch1, i_rx_ch2, i_rx_ch3, i_rx_ch4} = {c1[23:0], c2[23:0], c3[23:0], c4[23:0]};
        {i_knob_a, i_knob_b, i_knob_c} = {a, b, c};
        i_hp_mode = m;
        i_rx_valid = 1;
        bl = (2 * (255 - b) > 255) ? 255 : 2 * (255 - b);
        br = (2 * b > 255) ? 255 : 2 * b;
        case (m)
            hmr_pkg::dual_mono_with_sidetone_mode: {l, r} = {g(c1, a) + g(st, c), g(c2, b) + g(st, c)};
            hmr_pkg::stereo_balance_sidetone_mode: {l, r} = {g(c1, (a * bl) >> 8) + g(st, c), g(c2, (a * br) >> 8) + g(st, c)};
            hmr_pkg::two_pair_sidetone_mode: {l, r} = {g(c1, a) + g(c3, b) + g(st, c), g(c2, a) + g(c4, b) + g(st, c)};
            hmr_pkg::dual_mono_plus_pair_mode: {l, r} = {g(c1, a) + g(c3, c), g(c2, b) + g(c4, c)};
            default: {l, r} = {g(c1, a) + g(c2, b) + g(c3, c), g(c1, a) + g(c2, b) + g(c4, c)};
        endcase
        @(negedge i_clk);
        i_rx_valid = 0;
        chk_b("hp_valid", 1, o_hp_valid);
        chk_s("hp_left", sat(l), o_hp_left);
        chk_s("hp_right", sat(r), o_hp_right);
    endtask
    task automatic mic(longint s, logic mon, logic ton);
        @(negedge i_clk);
        i_mic_sample = s[23:0];
        i_mic_valid = 1;
        @(negedge i_clk);
        i_mic_valid = 0;
        st = s;
        chk_b("tx_valid", 1, o_tx_valid);
        chk_s("main_tx", mon ? s[23:0] : 24'h00_0000, o_main_tx);
        chk_s("tb_tx", ton ? s[23:0] : 24'h00_0000, o_tb_tx);
    endtask
    // Change one contact, let sync, state and tally settle
    task automatic push(int idx, logic v);
        @(negedge i_clk);
        press[idx] = v;
        repeat (4) @(negedge i_clk);
    endtask
    initial
    begin
        #100000;
        errors++;
        final_report();
    end
    initial
    begin
        repeat (4) @(negedge i_clk);
        i_rst = 0;
        repeat (4) @(negedge i_clk);
        chk_b("mic_mute", 0, o_mic_out_mute);
        mic(24'shF0_0000, 1, 0);
        for (int i = 0; i < 5; i++)
            frame(hmr_pkg::hp_mode_t'(i[2:0]), 24'sh10_0000, 24'shE0_0000, 24'sh04_0000, 24'shFD_0000, 8'h80, 8'hC0, 8'h40);
        for (int b = 0; b < 3; b++)
            frame(hmr_pkg::stereo_balance_sidetone_mode, 24'sh20_0000, 24'sh30_0000, 0, 0, 8'hFF, 8'(b * 128), 8'h10);
        frame(hmr_pkg::dual_mono_both_sides_mode, FULL, FULL, FULL, -FULL, 8'hFF, 8'hFF, 8'hFF);
        frame(hmr_pkg::two_pair_sidetone_mode, -FULL, -FULL, -FULL, -FULL, 8'hFF, 8'hFF, 8'hFF);
        push(0, 1);
        chk_b("main_on", 0, o_main_on);
        mic(24'sh12_3456, 0, 0);
        push(0, 0);
        push(3, 1);
        chk_b("tb_on", 1, o_tb_on);
        mic(24'sh00_0321, 1, 1);
        push(3, 0);
        push(1, 1);
        chk_b("tb_on", 1, o_tb_on);
        chk_b("tb_led_green", 1, o_tb_led_green);
        push(1, 0);
        chk_b("tb_on", 0, o_tb_on);
        chk_b("tb_led_red", 1, o_tb_led_red);
        push(2, 1);
        chk_b("main_on", 0, o_main_on);
        i_rc1_is_tally = 1;
        push(2, 1);
        chk_b("tally", 1, o_tally_out);
        push(0, 1);
        chk_b("tally", 0, o_tally_out);
        push(0, 0);
        i_main_mode = hmr_pkg::main_always_off;
        push(2, 0);
        chk_b("main_on", 0, o_main_on);
        chk_b("led_red", 1, o_main_led_red);
        i_led_scheme = 1;
        push(0, 0);
        chk_b("led_red", 0, o_main_led_red);
        chk_b("led_green", 1, o_main_led_green);
        i_main_mode = hmr_pkg::main_latching;
        push(0, 1);
        chk_b("main_on", 1, o_main_on);
        push(0, 0);
        push(0, 1);
        chk_b("main_on", 0, o_main_on);
        i_main_mode = hmr_pkg::main_always_on;
        push(0, 0);
        chk_b("main_on", 1, o_main_on);
        i_main_mode = hmr_pkg::main_push_to_talk;
        push(0, 1);
        chk_b("main_on", 1, o_main_on);
        for (int k = 0; k < 4; k++)
        begin
            {i_preamp_gain, i_phantom_en} = {k[1:0], k[0]};
            push(0, 0);
            chk_s("gain", {22'h0, k[1:0]}, {22'h0, o_preamp_gain});
            chk_b("phantom", k[0], o_phantom_on);
        end
        final_report();
    end
endmodule
`default_nettype wire
